// >>> dv/epfc_pulse_src.sv
/*
 * Model of the external pulse source on the count input pin.
 * Assumes a one-cycle go pulse starts a burst; the pin rests at idle_i.
 */
`timescale 1ns/1ps

module epfc_pulse_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [15:0] n_i,
    input wire logic [7:0] half_i,
    input wire logic idle_i,
    output logic pin_o,
    output logic busy_o
);
    logic [16:0] ph_reg;
    logic [7:0] cnt_reg;

    // ********************
    // burst generator
    // ********************
    // each level lasts half_i cycles; the bench never asks for fewer than 8
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_reg <= 17'h0_0000;
            cnt_reg <= 8'h00;
        end else if (go_i) begin
            ph_reg <= {n_i, 1'b0};
            cnt_reg <= 8'h00;
        end else if (ph_reg != 17'h0_0000) begin
            if (cnt_reg == half_i - 8'h01) begin
                cnt_reg <= 8'h00;
                ph_reg <= ph_reg - 17'h0_0001;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    // even phases high, odd phases low, then rest level
    assign busy_o = ph_reg != 17'h0_0000;
    assign pin_o = busy_o ? ~ph_reg[0] : idle_i;
endmodule

// >>> dv/epfc_top_asserts.sv
/*
 * Concurrent checks on the ports of the counter top module.
 * Assumes writes take effect in the cycle after the strobe.
 */
`timescale 1ns/1ps
`include "epfc_params.svh"

module epfc_top_asserts (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic EXTERNAL_COUNT_INPUT_I,
    input wire logic NEIGHBOUR_TIMER_OUTPUT_I,
    input wire logic COUNTER_INTERRUPT_O,
    input wire logic NEIGHBOUR_OUTPUT_PORT_PIN_O
);
    import epfc_pkg::*;
    logic [7:0] c1_reg;
    logic [7:0] c2_reg;

    // shadow copies of both control bytes
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            c1_reg <= 8'h00;
            c2_reg <= 8'h00;
        end else if (WR_I && ADDR_I == `EPFC_ADDR_CTRL1) begin
            c1_reg <= WDATA_I[7:0];
        end else if (WR_I && ADDR_I == `EPFC_ADDR_CTRL2) begin
            c2_reg <= WDATA_I[7:0];
        end
    end

    // decoded conditions; capt is a window capture mode with pin window
    wire logic run = c1_reg[1:0] == `EPFC_START_RUN;
    wire logic pulse = c1_reg[3:2] == 2'h2;
    wire logic pinwin = c1_reg[3:2] == 2'h3 && c2_reg[6:5] == 2'h0;
    wire logic capt = run && (pulse || pinwin);
    wire logic wedge = c2_reg[`EPFC_C2_WEDGE_BIT];
    wire logic nb_dis = c2_reg[`EPFC_C2_NBDIS_BIT];
    wire logic external_count_input = EXTERNAL_COUNT_INPUT_I;
    wire logic irq = COUNTER_INTERRUPT_O;
    wire logic wr1 = WR_I && ADDR_I == `EPFC_ADDR_CTRL1;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    // ********************
    // sequences and properties
    // ********************
    sequence s_soon;
        ##[1:4] irq;
    endsequence
    sequence s_quiet;
        ##1 !irq [*2];
    endsequence

    property p_fall_irq;
        capt && $fell(external_count_input) |-> s_soon;
    endproperty
    a_fall_irq: assert property (p_fall_irq)
        else $error("no irq at window fall");
    property p_rise_both;
        capt && wedge && $rose(external_count_input) |-> s_soon;
    endproperty
    a_rise_both: assert property (p_rise_both)
        else $error("no irq at window rise");
    property p_rise_quiet;
        capt && !wedge && $rose(external_count_input) |-> s_quiet;
    endproperty
    a_rise_quiet: assert property (p_rise_quiet)
        else $error("irq at rise, fall only");
    property p_start_irq;
        wr1 && WDATA_I[3:0] == 4'ha && c1_reg[1:0] == 2'h0 && wedge && external_count_input
            |-> s_soon;
    endproperty
    a_start_irq: assert property (p_start_irq)
        else $error("no irq at start");
    property p_stop_irq;
        wr1 && WDATA_I[1:0] == 2'h0 && run && pulse && external_count_input |-> s_soon;
    endproperty
    a_stop_irq: assert property (p_stop_irq)
        else $error("no irq at stop");
    property p_irq_pulse;
        irq |=> !irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq too long");
    property p_nb_route;
        c2_reg[6] && !nb_dis && $stable(c2_reg)
            |-> NEIGHBOUR_OUTPUT_PORT_PIN_O == $past(NEIGHBOUR_TIMER_OUTPUT_I);
    endproperty
    a_nb_route: assert property (p_nb_route)
        else $error("neighbour not routed");
    property p_nb_off;
        c2_reg[6] && nb_dis && $stable(c2_reg) |-> !NEIGHBOUR_OUTPUT_PORT_PIN_O;
    endproperty
    a_nb_off: assert property (p_nb_off)
        else $error("neighbour not suppressed");
    property p_flag_off;
        RD_I && ADDR_I == `EPFC_ADDR_STATUS && !run |=> RDATA_O[0] == 1'b0;
    endproperty
    a_flag_off: assert property (p_flag_off)
        else $error("flag set while stopped");
    property p_cmp_width;
        RD_I && ADDR_I == `EPFC_ADDR_CMP |=> RDATA_O[31:18] == 14'h0000;
    endproperty
    a_cmp_width: assert property (p_cmp_width)
        else $error("count too wide");
endmodule

bind epfc_top epfc_top_asserts u_epfc_top_asserts (.CLK_I, .RESET_I,
    .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .EXTERNAL_COUNT_INPUT_I,
    .NEIGHBOUR_TIMER_OUTPUT_I, .COUNTER_INTERRUPT_O,
    .NEIGHBOUR_OUTPUT_PORT_PIN_O);

// >>> dv/tb.sv
/*
 * Self-checking bench for the counter top module.
 * Assumes the package is compiled first.
 */
`timescale 1ns/1ps
`include "epfc_params.svh"

module tb;
    import epfc_pkg::*;
    typedef struct {logic [31:0] lo; logic [31:0] hi;} epfc_exp_type;
    localparam logic [7:0] A1 = `EPFC_ADDR_CTRL1;
    localparam logic [7:0] A2 = `EPFC_ADDR_CTRL2;
    localparam logic [7:0] AC = `EPFC_ADDR_CMP;
    localparam logic [7:0] AS = `EPFC_ADDR_STATUS;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic nb_in = 1'b0;
    logic go = 1'b0;
    logic idle = 1'b0;
    logic [15:0] n = 16'h0000;
    logic [7:0] half = 8'h08;
    logic rd_q = 1'b0;
    wire logic [31:0] rdata;
    wire logic external_count_input, irq, nb_pin, busy;
    epfc_exp_type eq[$];
    epfc_exp_type e;
    int irq_t[$];
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int irq_cnt = 0;
    int seed = 32'h42d6_5917;
    int base, c, p, w, k, t0;

    epfc_top u_epfc_top (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
        .EXTERNAL_COUNT_INPUT_I(external_count_input), .NEIGHBOUR_TIMER_OUTPUT_I(nb_in),
        .COUNTER_INTERRUPT_O(irq), .NEIGHBOUR_OUTPUT_PORT_PIN_O(nb_pin));
    epfc_pulse_src u_epfc_pulse_src (.clk_i(clk), .rst_i(rst), .go_i(go),
        .n_i(n), .half_i(half), .idle_i(idle), .pin_o(external_count_input), .busy_o(busy));

    // 40 ns clock
    always #20 clk = ~clk;

    // ********************
    // shared tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo,
                      input logic [31:0] hi);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        eq.push_back('{lo, hi});
        @(posedge clk);
        rd_s <= 1'b0;
    endtask
    task automatic launch(input int np, input logic [7:0] hp);
        @(posedge clk);
        n <= np[15:0];
        half <= hp;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic drain();
        @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
    endtask
    task automatic level(input logic v, input int cycles);
        @(posedge clk);
        idle <= v;
        repeat (cycles) @(posedge clk);
    endtask
    task automatic wait_irq(input int want, input int lim);
        int i;
        for (i = 0; i < lim && irq_cnt < want; i++) @(posedge clk);
        chk("irq arrival", irq_cnt, want);
    endtask

    // monitor: read data, interrupt times, random neighbour, time limit
    always @(posedge clk) begin
        cyc++;
        nb_in <= 1'($random(seed));
        if (rd_q) begin
            e = eq.pop_front();
            chk("rd", rdata inside {[e.lo:e.hi]} ? e.lo : rdata, e.lo);
        end
        rd_q <= rd_s;
        if (irq === 1'b1) begin
            irq_cnt++;
            irq_t.push_back(cyc);
        end
        if (cyc == 60000) begin
            error_cnt++;
            results();
        end
    end

    // ********************
    // main sequence
    // ********************
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(AS, 0, 0);
        rd(8'h14, 0, 0);
        wr(AS, 32'h0000_0002);
        rd(AS, 0, 0);
        wr(A1, 32'h0000_0004);
        rd(AC, 32'h0003_ffff, 32'h0003_ffff);
        // event counting against random compare values
        for (k = 0; k < 3; k++) begin
            c = 2 + ($random(seed) & 3);
            p = 3 * c + ($random(seed) & 7);
            wr(A1, 32'h0000_0094);
            wr(AC, c);
            wr(A1, 32'h0000_0016);
            base = irq_cnt;
            launch(p, 8'h08);
            drain();
            repeat (4) @(posedge clk);
            chk("event irqs", irq_cnt - base, p / c);
        end
        // pulse width, both interrupt edge choices
        for (w = 0; w < 2; w++) begin
            wr(A2, w << 4);
            wr(A1, 32'h0000_0088);
            base = irq_cnt;
            wr(A1, 32'h0000_000a);
            launch(1, 8'd40);
            drain();
            rd(AC, 19, 22);
            launch(1, 8'd40);
            drain();
            rd(AC, 38, 44);
            chk("pulse irqs", irq_cnt - base, 2 * (1 + w));
            wr(A1, 32'h0000_0088);
            rd(AC, 0, 0);
        end
        // start and stop with the pin high, both edges selected
        level(1'b1, 4);
        base = irq_cnt;
        wr(A1, 32'h0000_000a);
        repeat (6) @(posedge clk);
        chk("start irq", irq_cnt - base, 1);
        wr(A1, 32'h0000_0008);
        repeat (6) @(posedge clk);
        chk("stop irq", irq_cnt - base, 2);
        level(1'b0, 10);
        // pin as window, constant high input, both edge selects
        for (w = 0; w < 2; w++) begin
            wr(A2, w << 7);
            wr(A1, 32'h0000_009c);
            wr(A1, 32'h0000_001e);
            level(1'b1, 20);
            rd(AS, 1, 1);
            level(1'b0, 10);
            rd(AC, 1, 1);
            rd(AS, 0, 0);
        end
        // internal window generator, high 2 and low 1 source periods
        wr(A2, 32'h0000_0030);
        wr(A1, 32'h0000_009c);
        wr(8'h0c, 32'h0000_00ef);
        base = irq_cnt;
        t0 = irq_t.size();
        launch(1200, 8'h08);
        wr(A1, 32'h0000_001e);
        wait_irq(base + 2, 14000);
        rd(AC, 511, 513);
        wait_irq(base + 3, 6000);
        chk("high len", irq_t[t0 + 1] - irq_t[t0], 8192);
        chk("low len", irq_t[t0 + 2] - irq_t[t0 + 1], 4096);
        // neighbour output routed then suppressed
        wr(A1, 32'h0000_009c);
        wr(A2, 32'h0000_0040);
        repeat (20) @(posedge clk);
        wr(A2, 32'h0000_0042);
        repeat (20) @(posedge clk);
        results();
    end
endmodule

// >>> logic/epfc_params.svh
/*
 * Constants of the counter: offsets, fields, reset values, divider taps.
 * Assumes inclusion by bare name wherever the macros are used.
 */
`ifndef EPFC_PARAMS_SVH
`define EPFC_PARAMS_SVH

// ********************
// register byte offsets
// ********************
`define EPFC_ADDR_CTRL1 8'h00
`define EPFC_ADDR_CTRL2 8'h04
`define EPFC_ADDR_CMP 8'h08
`define EPFC_ADDR_WIN 8'h0C
`define EPFC_ADDR_STATUS 8'h10

// ********************
// counter_control_first fields
// ********************
`define EPFC_C1_START_LSB 0
`define EPFC_C1_MODE_LSB 2
`define EPFC_C1_CLKSRC_BIT 4
`define EPFC_C1_INTCLK_LSB 5
`define EPFC_C1_CLEAR_BIT 7

// ********************
// counter_control_second fields
// ********************
`define EPFC_C2_NBDIS_BIT 1
`define EPFC_C2_WCLK_LSB 2
`define EPFC_C2_WEDGE_BIT 4
`define EPFC_C2_WSRC_LSB 5
`define EPFC_C2_EDGE_BIT 7

// ********************
// window register and status fields
// ********************
`define EPFC_WIN_LOW_LSB 0
`define EPFC_WIN_HIGH_LSB 4
`define EPFC_ST_OPER_BIT 0
`define EPFC_ST_OVF_BIT 1

// ********************
// codes, reset values, divider taps
// ********************
`define EPFC_START_STOP 2'h0
`define EPFC_START_RUN 2'h2
`define EPFC_WSRC_PIN 2'h0
`define EPFC_WSRC_GEN 2'h1
`define EPFC_CMP_RESET 18'h3_FFFF
`define EPFC_COUNT_MAX 18'h3_FFFF
`define EPFC_WIN_FULL 5'h10
`define EPFC_WTAP_BASE 12
`define EPFC_DIV_W 15

`endif

// >>> logic/epfc_pkg.sv
/*
 * Types of the event/pulse/frequency counter: modes, window phase states
 * and the single packed state record of the top module.
 * Assumes epfc_params.svh is on the include path.
 */
package epfc_pkg;
`include "epfc_params.svh"

    // counting modes held in counter_control_first
    typedef enum logic [1:0] {
        EPFC_MODE_OFF = 2'h0,
        EPFC_MODE_EVENT = 2'h1,
        EPFC_MODE_PULSE = 2'h2,
        EPFC_MODE_FREQ = 2'h3
    } epfc_mode_type;

    // internal window generator phases, one-hot
    typedef enum logic [2:0] {
        EPFC_WIN_IDLE = 3'b001,
        EPFC_WIN_HIGH = 3'b010,
        EPFC_WIN_LOW = 3'b100
    } epfc_win_type;

    // software-visible configuration
    typedef struct packed {
        logic [1:0] counter_start_control;
        epfc_mode_type mode;
        logic count_clock_source_select;
        logic [1:0] internal_clock_select;
        logic input_edge_select;
        logic [1:0] window_source_select;
        logic window_interrupt_edge_select;
        logic [1:0] window_clock_select;
        logic neighbour_output_pin_disable;
        logic [17:0] compare_capture_value;
        logic [3:0] window_high_setting;
        logic [3:0] window_low_setting;
    } epfc_cfg_type;

    // whole state of the top module
    typedef struct packed {
        epfc_cfg_type cfg;
        logic [17:0] count;
        logic overflow_status_flag;
        logic [`EPFC_DIV_W-1:0] div;
        logic external_count_input_q;
        logic and_q;
        logic gate_q;
        epfc_win_type win_st;
        logic [4:0] win_left;
        logic [3:0] low_lat;
        logic irq;
        logic nb_pin;
        logic [31:0] rdata;
    } epfc_state_type;
endpackage

// >>> logic/epfc_top.sv
/*
 * 18-bit up-counter with event counting, pulse width measurement and
 * frequency measurement through a window gate, plus an internal window
 * generator. Registers are reached over a plain strobe port.
 * Assumes all inputs are synchronous to CLK_I and the external pulse
 * source keeps each level for at least two clock cycles.
 */
`timescale 1ns/1ps
`include "epfc_params.svh"

// Function
// (R01) event mode counts each falling edge of the external count input.
// (R02) event mode: match with compare value interrupts and clears counter.
// (R03) external input rate stays at or below one sixteenth of clock.
// (R04) external input holds each level at least two machine cycles.
// (R05) pulse mode counts falling edges of input AND internal clock.
// (R06) window fall, or both edges, raises the interrupt in capture modes.
// (R07) software reads count while stopped then clears it.
// (R08) without clear, counting resumes from the stopped value.
// (R09) wrap from top to zero sets overflow, held until clear.
// (R10) stopping pulse mode while input high raises the interrupt.
// (R11) starting pulse mode, both edges, input high interrupts at once.
// (R12) input falling while internal clock high adds one extra count.
// (R13) frequency mode counts input edges only while window high.
// (R14) window source 00 is the pin; others are generator or neighbour.
// (R15) operating flag shows window state in frequency mode only.
// (R16) neighbour pin disable 0 routes neighbour output, 1 suppresses it.
// (R17) window phases last sixteen minus setting source periods.
// (R18) window has high and low phases from separate four-bit fields.
// (R19) generated window may start one source period late.
// (R20) low setting written during low phase applies next low phase.
// (R21) edge select 1 adds one count on each window falling edge.
// (R22) edge select 0 counts input AND window; high input gives one.
// (R23) window interrupt edge select: 0 falling, 1 both edges.
// (R24) operating flag 1 only counting in high phase, else 0.
// (R25) counter is 18 bits; overflow flag is read-only.
module epfc_top (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic EXTERNAL_COUNT_INPUT_I,
    input wire logic NEIGHBOUR_TIMER_OUTPUT_I,
    output logic COUNTER_INTERRUPT_O,
    output logic NEIGHBOUR_OUTPUT_PORT_PIN_O
);
    import epfc_pkg::*;

    epfc_state_type s_reg;
    epfc_state_type s_next;

    // ********************
    // combinational helpers
    // ********************
    logic running;
    logic src_clk;
    logic win_tick;
    logic gate;
    logic and_now;
    logic in_fall;
    logic in_edge;
    logic gate_rise;
    logic gate_fall;
    logic do_inc;
    logic do_clear;
    logic [17:0] inc;
    logic [`EPFC_DIV_W-1:0] div_inc;
    logic [4:0] high_len;
    logic [4:0] low_len;
    logic [31:0] rd_val;

    // ********************
    // next-state logic
    // ********************
    always_comb begin
        s_next = s_reg;
        running = (s_reg.cfg.counter_start_control == `EPFC_START_RUN);
        div_inc = s_reg.div + `EPFC_DIV_W'(1);
        s_next.div = div_inc;
        // internal source clock is a divider tap chosen by software
        unique case (s_reg.cfg.internal_clock_select)
            2'h0: src_clk = s_reg.div[0];
            2'h1: src_clk = s_reg.div[2];
            2'h2: src_clk = s_reg.div[6];
            2'h3: src_clk = s_reg.div[10];
        endcase
        // window source tick: 2^12, 2^13 or 2^14 clocks, code 3 as 2^14
        unique case (s_reg.cfg.window_clock_select)
            2'h0: win_tick = (div_inc[`EPFC_WTAP_BASE-1:0] == '0);
            2'h1: win_tick = (div_inc[`EPFC_WTAP_BASE:0] == '0);
            default: win_tick = (div_inc[`EPFC_WTAP_BASE+1:0] == '0);
        endcase
        high_len = `EPFC_WIN_FULL - {1'b0, s_reg.cfg.window_high_setting};
        low_len = `EPFC_WIN_FULL - {1'b0, s_reg.low_lat};
        s_next.irq = 1'b0;
        s_next.external_count_input_q = EXTERNAL_COUNT_INPUT_I;

        // internal window generator, synchronised to the divider
        if (!running) begin
            s_next.win_st = EPFC_WIN_IDLE;
        end else if (win_tick) begin
            unique case (s_reg.win_st)
                EPFC_WIN_IDLE: begin
                    // first phase waits for a divider tick [R19]
                    s_next.win_st = EPFC_WIN_HIGH;
                    s_next.win_left = high_len; // [R17] [R18]
                end
                EPFC_WIN_HIGH: begin
                    if (s_reg.win_left == 5'h01) begin
                        s_next.win_st = EPFC_WIN_LOW;
                        s_next.win_left = low_len; // [R17]
                    end else begin
                        s_next.win_left = s_reg.win_left - 5'h01;
                    end
                end
                EPFC_WIN_LOW: begin
                    // low length latched at phase start [R20]
                    if (s_reg.win_left == 5'h01) begin
                        s_next.win_st = EPFC_WIN_HIGH;
                        s_next.win_left = high_len;
                    end else begin
                        s_next.win_left = s_reg.win_left - 5'h01;
                    end
                end
            endcase
        end
        // low setting frozen while a low phase runs [R20]
        if (s_reg.win_st != EPFC_WIN_LOW) begin
            s_next.low_lat = s_reg.cfg.window_low_setting;
        end

        // window gate selection [R14]
        unique case (s_reg.cfg.window_source_select)
            `EPFC_WSRC_PIN: gate = EXTERNAL_COUNT_INPUT_I;
            `EPFC_WSRC_GEN: gate = (s_reg.win_st == EPFC_WIN_HIGH);
            default: gate = NEIGHBOUR_TIMER_OUTPUT_I;
        endcase
        // pulse mode: the pin itself is the window
        if (s_reg.cfg.mode == EPFC_MODE_PULSE) begin
            gate = EXTERNAL_COUNT_INPUT_I;
        end
        gate = gate && running;
        s_next.gate_q = gate;
        gate_rise = gate && !s_reg.gate_q;
        gate_fall = !gate && s_reg.gate_q;
        in_fall = !EXTERNAL_COUNT_INPUT_I && s_reg.external_count_input_q;
        in_edge = EXTERNAL_COUNT_INPUT_I != s_reg.external_count_input_q;

        // counting term per mode
        and_now = 1'b0;
        do_inc = 1'b0;
        unique case (s_reg.cfg.mode)
            EPFC_MODE_EVENT: begin
                do_inc = running && in_fall; // [R01]
            end
            EPFC_MODE_PULSE: begin
                // AND with source clock; a window fall while the
                // source is high falls the AND too [R05] [R12]
                and_now = gate && src_clk;
            end
            EPFC_MODE_FREQ: begin
                if (s_reg.cfg.input_edge_select) begin
                    // input edges inside an open gate, plus one at close
                    do_inc = (gate && s_reg.gate_q && in_edge) ||
                        gate_fall; // [R13] [R21]
                end else begin
                    and_now = gate && EXTERNAL_COUNT_INPUT_I; // [R22]
                end
            end
            default: begin
                do_inc = 1'b0;
            end
        endcase
        s_next.and_q = and_now;
        if (s_reg.and_q && !and_now) begin
            do_inc = 1'b1;
        end

        // window interrupt in the capture modes [R06] [R23]
        if (s_reg.cfg.mode == EPFC_MODE_PULSE ||
            s_reg.cfg.mode == EPFC_MODE_FREQ) begin
            // stop or start writes move the window too [R10] [R11]
            if (gate_fall ||
                (gate_rise && s_reg.cfg.window_interrupt_edge_select)) begin
                s_next.irq = 1'b1;
            end
        end

        // software clear of counter and overflow [R07]
        do_clear = WR_I && (ADDR_I == `EPFC_ADDR_CTRL1) &&
            WDATA_I[`EPFC_C1_CLEAR_BIT];
        if (do_clear) begin
            s_next.count = '0;
            s_next.overflow_status_flag = 1'b0;
        end
        // counter advance; holds otherwise so counting resumes [R08]
        inc = s_reg.count + 18'h0_0001;
        if (do_inc) begin
            if (s_reg.cfg.mode == EPFC_MODE_EVENT &&
                inc == s_reg.cfg.compare_capture_value) begin
                s_next.count = '0; // [R02]
                s_next.irq = 1'b1;
            end else begin
                s_next.count = inc; // [R25]
            end
            if (s_reg.count == `EPFC_COUNT_MAX) begin
                // set beats a same-cycle clear [R09]
                s_next.overflow_status_flag = 1'b1;
            end
        end

        // neighbour output routing to its port pin [R16]
        s_next.nb_pin = !s_reg.cfg.neighbour_output_pin_disable &&
            NEIGHBOUR_TIMER_OUTPUT_I;

        // register writes
        if (WR_I) begin
            unique case (ADDR_I)
                `EPFC_ADDR_CTRL1: begin
                    s_next.cfg.counter_start_control =
                        WDATA_I[`EPFC_C1_START_LSB +: 2];
                    s_next.cfg.mode =
                        epfc_mode_type'(WDATA_I[`EPFC_C1_MODE_LSB +: 2]);
                    s_next.cfg.count_clock_source_select =
                        WDATA_I[`EPFC_C1_CLKSRC_BIT];
                    s_next.cfg.internal_clock_select =
                        WDATA_I[`EPFC_C1_INTCLK_LSB +: 2];
                end
                `EPFC_ADDR_CTRL2: begin
                    s_next.cfg.input_edge_select = WDATA_I[`EPFC_C2_EDGE_BIT];
                    s_next.cfg.window_source_select =
                        WDATA_I[`EPFC_C2_WSRC_LSB +: 2];
                    s_next.cfg.window_interrupt_edge_select =
                        WDATA_I[`EPFC_C2_WEDGE_BIT];
                    s_next.cfg.window_clock_select =
                        WDATA_I[`EPFC_C2_WCLK_LSB +: 2];
                    s_next.cfg.neighbour_output_pin_disable =
                        WDATA_I[`EPFC_C2_NBDIS_BIT];
                end
                `EPFC_ADDR_CMP: begin
                    s_next.cfg.compare_capture_value = WDATA_I[17:0];
                end
                `EPFC_ADDR_WIN: begin
                    s_next.cfg.window_high_setting =
                        WDATA_I[`EPFC_WIN_HIGH_LSB +: 4];
                    s_next.cfg.window_low_setting =
                        WDATA_I[`EPFC_WIN_LOW_LSB +: 4];
                end
                default: begin
                    s_next.cfg = s_reg.cfg; // status is read-only [R25]
                end
            endcase
        end

        // read mux; answer stands one cycle after the strobe
        rd_val = '0;
        unique case (ADDR_I)
            `EPFC_ADDR_CTRL1: begin
                rd_val[`EPFC_C1_START_LSB +: 2] =
                    s_reg.cfg.counter_start_control;
                rd_val[`EPFC_C1_MODE_LSB +: 2] = s_reg.cfg.mode;
                rd_val[`EPFC_C1_CLKSRC_BIT] =
                    s_reg.cfg.count_clock_source_select;
                rd_val[`EPFC_C1_INTCLK_LSB +: 2] =
                    s_reg.cfg.internal_clock_select;
            end
            `EPFC_ADDR_CTRL2: begin
                rd_val[`EPFC_C2_EDGE_BIT] = s_reg.cfg.input_edge_select;
                rd_val[`EPFC_C2_WSRC_LSB +: 2] =
                    s_reg.cfg.window_source_select;
                rd_val[`EPFC_C2_WEDGE_BIT] =
                    s_reg.cfg.window_interrupt_edge_select;
                rd_val[`EPFC_C2_WCLK_LSB +: 2] = s_reg.cfg.window_clock_select;
                rd_val[`EPFC_C2_NBDIS_BIT] =
                    s_reg.cfg.neighbour_output_pin_disable;
            end
            `EPFC_ADDR_CMP: begin
                // event mode shows the compare value, else the count
                if (s_reg.cfg.mode == EPFC_MODE_EVENT) begin
                    rd_val[17:0] = s_reg.cfg.compare_capture_value;
                end else begin
                    rd_val[17:0] = s_reg.count;
                end
            end
            `EPFC_ADDR_WIN: begin
                rd_val[`EPFC_WIN_HIGH_LSB +: 4] = s_reg.cfg.window_high_setting;
                rd_val[`EPFC_WIN_LOW_LSB +: 4] = s_reg.cfg.window_low_setting;
            end
            `EPFC_ADDR_STATUS: begin
                rd_val[`EPFC_ST_OVF_BIT] = s_reg.overflow_status_flag;
                // gate state, frequency mode only [R15] [R24]
                rd_val[`EPFC_ST_OPER_BIT] = running &&
                    (s_reg.cfg.mode == EPFC_MODE_FREQ) && s_reg.gate_q;
            end
            default: begin
                rd_val = '0;
            end
        endcase
        s_next.rdata = RD_I ? rd_val : '0;
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            s_reg <= '0;
            s_reg.cfg.compare_capture_value <= `EPFC_CMP_RESET;
            s_reg.win_st <= EPFC_WIN_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops
    assign RDATA_O = s_reg.rdata;
    assign COUNTER_INTERRUPT_O = s_reg.irq;
    assign NEIGHBOUR_OUTPUT_PORT_PIN_O = s_reg.nb_pin;
endmodule
